/* File: hw/fpsm_monitor.sv */
// Sync FIFO with read-phase monitor, averaging, threshold interrupt and auto offset
`timescale 1ns/10ps
module fpsm_monitor #(
	parameter int WIDTH = 14,
	parameter int CTRL_DIV = fpsm_pkg::CTRL_DIV,
	parameter int CYCLE_TICKS = fpsm_pkg::CYCLE_TICKS
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic data_clock_in,
	input wire logic [WIDTH-1:0] sample_in,
	input wire logic converter_clock,
	output logic [WIDTH-1:0] sample_out,
	input wire fpsm_pkg::fpsm_reg_req_type reg_req,
	output logic [7:0] reg_rdata,
	input wire logic sync_irq_enable,
	output logic sync_irq
);
	typedef enum {FPSM_IDLE, FPSM_RUN} fpsm_state_type;
	fpsm_state_type state_reg;
	logic [2:0] wr_ptr_reg, rd_ptr_reg;
	logic [1:0] readout_offset_reg, optimal_offset_reg;
	logic surveillance_enable_reg, auto_correct_enable_reg, threshold_select_reg;
	logic [3:0] averaging_shift_reg;
	logic [14:0] avg_reg;
	logic [2:0] fifo_read_position_reg;
	logic err_acc_reg, err_reg, valid_reg, position_changed_flag_reg, irq_pending_reg;
	logic [$clog2(CTRL_DIV)-1:0] div_reg;
	logic [$clog2(CYCLE_TICKS)-1:0] tick_cnt_reg;
	logic [7:0] rdata_reg;
	logic tick_reg;

	wire logic [2:0] rd_addr = rd_ptr_reg + {1'b0, readout_offset_reg};
	wire logic [2:0] cur_pos = wr_ptr_reg - rd_addr;
	wire logic collision = (cur_pos == fpsm_pkg::POS_LOW);
	wire logic [3:0] eff_shift = (averaging_shift_reg > fpsm_pkg::SHIFT_MAX) ?
		fpsm_pkg::SHIFT_MAX : averaging_shift_reg;
	wire logic signed [15:0] delta = $signed({1'b0, cur_pos, 12'h000}) - $signed({1'b0, avg_reg});
	wire logic signed [15:0] step = delta >>> eff_shift;
	wire logic [14:0] avg_next = avg_reg + step[14:0];
	wire logic [2:0] pos_next = avg_next[14:fpsm_pkg::AVG_FRAC];
	wire logic end_of_cycle = (state_reg == FPSM_RUN) && tick_reg &&
		(tick_cnt_reg == ($clog2(CYCLE_TICKS))'(CYCLE_TICKS - 1));
	wire logic keep_running = surveillance_enable_reg || auto_correct_enable_reg;
	wire logic hit_narrow = (pos_next == fpsm_pkg::POS_LOW) ||
		(pos_next == fpsm_pkg::POS_HIGH);
	wire logic hit_wide = hit_narrow || (pos_next == fpsm_pkg::POS_LOW_WIDE) ||
		(pos_next == fpsm_pkg::POS_HIGH_WIDE);
	wire logic hit = threshold_select_reg ? hit_wide : hit_narrow;
	wire logic [1:0] optimal_next = readout_offset_reg + 2'(pos_next - fpsm_pkg::POS_CENTER);
	wire logic wr_status = reg_req.wr && (reg_req.addr == fpsm_pkg::ADDR_STATUS_OFFSET);
	wire logic wr_mode = reg_req.wr && (reg_req.addr == fpsm_pkg::ADDR_MODE_CONTROL);
	wire logic [1:0] offset_readback = auto_correct_enable_reg ? optimal_offset_reg :
		readout_offset_reg;
	wire logic [7:0] status_word = {err_reg, fifo_read_position_reg, valid_reg,
		position_changed_flag_reg, offset_readback};
	wire logic [7:0] rdata_next = (reg_req.addr == fpsm_pkg::ADDR_STATUS_OFFSET) ? status_word :
		8'h00;

	fpsm_sample_fifo #(.WIDTH(WIDTH), .DEPTH_LOG2(3)) u_fifo (
		.clock(clock),
		.wr_en(data_clock_in),
		.wr_addr(wr_ptr_reg),
		.wr_data(sample_in),
		.rd_addr(rd_addr),
		.rd_data(sample_out)
	);

	// Pointers advance on their own strobes
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr_reg <= 3'h0;
			rd_ptr_reg <= 3'h0;
		end else begin
			if (data_clock_in) begin
				wr_ptr_reg <= wr_ptr_reg + 3'h1;
			end
			if (converter_clock) begin
				rd_ptr_reg <= rd_ptr_reg + 3'h1;
			end
		end
	end

	// Controller clock enable
	always_ff @(posedge clock) begin
		if (rst) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 1'b1;
			tick_reg <= (div_reg == ($clog2(CTRL_DIV))'(CTRL_DIV - 1));
		end
	end

	// Register writes
	always_ff @(posedge clock) begin
		if (rst) begin
			surveillance_enable_reg <= 1'b0;
			auto_correct_enable_reg <= 1'b0;
			averaging_shift_reg <= fpsm_pkg::SHIFT_RESET;
			threshold_select_reg <= 1'b0;
		end else if (wr_mode) begin
			surveillance_enable_reg <= reg_req.wdata[fpsm_pkg::FIELD_SURV];
			auto_correct_enable_reg <= reg_req.wdata[fpsm_pkg::FIELD_AUTO];
			averaging_shift_reg <= reg_req.wdata[fpsm_pkg::FIELD_SHIFT_HI:fpsm_pkg::FIELD_SHIFT_LO];
			threshold_select_reg <= reg_req.wdata[fpsm_pkg::FIELD_THRESH];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			readout_offset_reg <= fpsm_pkg::OFFSET_RESET;
		end else if (end_of_cycle && auto_correct_enable_reg) begin
			readout_offset_reg <= optimal_next;
		end else if (wr_status) begin
			readout_offset_reg <= reg_req.wdata[1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (reg_req.rd) begin
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;

	// Measurement sequencer
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= FPSM_RUN;
			tick_cnt_reg <= '0;
		end else begin
			case (state_reg)
				FPSM_IDLE: begin
					if (keep_running || wr_mode) begin
						state_reg <= FPSM_RUN;
					end
				end
				FPSM_RUN: begin
					if (tick_reg) begin
						tick_cnt_reg <= tick_cnt_reg + 1'b1;
					end
					if (end_of_cycle) begin
						tick_cnt_reg <= '0;
						if (!keep_running) begin
							state_reg <= FPSM_IDLE;
						end
					end
				end
				default: state_reg <= FPSM_IDLE;
			endcase
		end
	end

	// Averaging and status capture
	always_ff @(posedge clock) begin
		if (rst) begin
			avg_reg <= {fpsm_pkg::POS_CENTER, 12'h000};
			err_acc_reg <= 1'b0;
			err_reg <= 1'b0;
			valid_reg <= 1'b0;
			fifo_read_position_reg <= 3'h0;
			position_changed_flag_reg <= 1'b0;
			optimal_offset_reg <= fpsm_pkg::OFFSET_RESET;
		end else if ((state_reg == FPSM_RUN) && tick_reg) begin
			avg_reg <= avg_next;
			err_acc_reg <= end_of_cycle ? 1'b0 : (err_acc_reg || collision);
			if (end_of_cycle) begin
				fifo_read_position_reg <= pos_next;
				err_reg <= err_acc_reg || collision;
				valid_reg <= 1'b1;
				position_changed_flag_reg <= surveillance_enable_reg &&
					({err_acc_reg || collision, pos_next} !=
					{err_reg, fifo_read_position_reg});
				optimal_offset_reg <= optimal_next;
			end
		end
	end

	// Sync interrupt
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_pending_reg <= 1'b0;
			sync_irq <= 1'b0;
		end else begin
			if (!sync_irq_enable) begin
				irq_pending_reg <= 1'b0;
			end else if (end_of_cycle && surveillance_enable_reg && hit) begin
				irq_pending_reg <= 1'b1;
			end
			sync_irq <= irq_pending_reg && sync_irq_enable;
		end
	end

	default clocking fpsm_cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence seq_cycle_end;
		end_of_cycle;
	endsequence
	sequence seq_surv_hit;
		seq_cycle_end ##0 (surveillance_enable_reg && hit && sync_irq_enable);
	endsequence

	AST_POS_MATCHES_AVG: assert property (seq_cycle_end
		|=> fifo_read_position_reg == $past(pos_next))
		else $error("Read position not taken from average");
	AST_ERR_FROM_COLLISION: assert property (seq_cycle_end ##0 !err_acc_reg ##0 !collision
		|=> !err_reg)
		else $error("Error bit set without collision");
	AST_VALID_AFTER_CYCLE: assert property ($rose(valid_reg) |-> $past(end_of_cycle))
		else $error("Valid rose outside a cycle end");
	AST_CHANGE_NEEDS_SURV: assert property (seq_cycle_end ##0 !surveillance_enable_reg
		|=> !position_changed_flag_reg)
		else $error("Change flag set without surveillance");
	AST_OFFSET_WRITE: assert property (wr_status && !(end_of_cycle && auto_correct_enable_reg)
		|=> readout_offset_reg == $past(reg_req.wdata[1:0]))
		else $error("Offset write not applied");
	AST_READBACK_AUTO: assert property (reg_req.rd && auto_correct_enable_reg &&
		reg_req.addr == fpsm_pkg::ADDR_STATUS_OFFSET
		|=> reg_rdata[1:0] == $past(optimal_offset_reg))
		else $error("Auto readback wrong");
	AST_STOP_AFTER_CYCLE: assert property (seq_cycle_end ##0 !keep_running
		|=> state_reg == FPSM_IDLE)
		else $error("Measurement did not stop");
	AST_SYNC_IRQ: assert property (seq_surv_hit ##1 sync_irq_enable |=> sync_irq)
		else $error("Sync interrupt missing");
	AST_AUTO_UPDATE: assert property (seq_cycle_end ##0 auto_correct_enable_reg
		|=> readout_offset_reg == $past(optimal_next))
		else $error("Auto offset not loaded");
	AST_NARROW_THRESH: assert property (!threshold_select_reg && hit
		|-> pos_next inside {3'h0, 3'h7})
		else $error("Narrow threshold wrong");
	AST_WIDE_THRESH: assert property (threshold_select_reg && pos_next == 3'h1 |-> hit)
		else $error("Wide threshold wrong");
	AST_IRQ_BLOCKED: assert property (!sync_irq_enable |=> !irq_pending_reg ##1 !sync_irq)
		else $error("Interrupt not blocked");
	AST_WRAP: assert property (data_clock_in && wr_ptr_reg == 3'h7 |=> wr_ptr_reg == 3'h0)
		else $error("Write pointer did not wrap");
endmodule // fpsm_monitor

/* File: hw/fpsm_pkg.sv */
// Package with register map, field layout and timing constants of the FIFO phase monitor
package fpsm_pkg;
	localparam logic [4:0] ADDR_STATUS_OFFSET = 5'h07;
	localparam logic [4:0] ADDR_MODE_CONTROL = 5'h08;
	localparam int FIELD_ERR = 7;
	localparam int FIELD_POS_HI = 6;
	localparam int FIELD_POS_LO = 4;
	localparam int FIELD_VALID = 3;
	localparam int FIELD_CHANGED = 2;
	localparam int FIELD_SURV = 7;
	localparam int FIELD_AUTO = 6;
	localparam int FIELD_SHIFT_HI = 5;
	localparam int FIELD_SHIFT_LO = 2;
	localparam int FIELD_THRESH = 0;
	localparam logic [1:0] OFFSET_RESET = 2'h0;
	localparam logic [3:0] SHIFT_RESET = 4'h0;
	localparam logic [3:0] SHIFT_MAX = 4'hc;
	localparam logic [2:0] POS_LOW = 3'h0;
	localparam logic [2:0] POS_LOW_WIDE = 3'h1;
	localparam logic [2:0] POS_HIGH_WIDE = 3'h6;
	localparam logic [2:0] POS_HIGH = 3'h7;
	localparam logic [2:0] POS_CENTER = 3'h4;
	localparam int AVG_FRAC = 12;
	localparam int CTRL_DIV = 16;
	localparam int CYCLE_TICKS = 8;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} fpsm_reg_req_type;
endpackage

/* File: hw/fpsm_sample_fifo.sv */
// Eight-entry sample FIFO between the data clock in stream and the converter side
`timescale 1ns/10ps
module fpsm_sample_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH_LOG2 = 3
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [DEPTH_LOG2-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [DEPTH_LOG2-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // fpsm_sample_fifo

/* File: testbench/fpsm_host_model.sv */
// Host model: register accesses and input stream strobes for the phase monitor
`timescale 1ns/10ps
module fpsm_host_model (
	input wire logic clock,
	output fpsm_pkg::fpsm_reg_req_type reg_req,
	input wire logic [7:0] reg_rdata,
	output logic data_clock_in,
	output logic converter_clock,
	output logic [13:0] sample_in
);
	int wcnt = 0;
	initial begin
		reg_req = '0;
		data_clock_in = 1'b0;
		converter_clock = 1'b0;
		sample_in = 14'h0000;
	end
	// Mode words keep shift <= 12; auto only with surveillance on, irq enable high for the row mode words only
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clock);
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clock);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		@(negedge clock);
		q = reg_rdata;
	endtask
	task automatic push(input int nw, input int nr);
		repeat (nw) begin
			@(negedge clock);
			sample_in = 14'h0a00 + 14'(wcnt);
			data_clock_in = 1'b1;
			wcnt++;
			@(negedge clock);
			data_clock_in = 1'b0;
			sample_in = ~sample_in;
		end
		repeat (nr) begin
			@(negedge clock);
			converter_clock = 1'b1;
			@(negedge clock);
			converter_clock = 1'b0;
		end
	endtask
endmodule // fpsm_host_model

/* File: testbench/fpsm_monitor_tb.sv */
// Self-checking bench for the FIFO phase monitor
`timescale 1ns/10ps
module fpsm_monitor_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic sync_irq_enable = 1'b0;
	logic data_clock_in, converter_clock, sync_irq, seen;
	logic [13:0] sample_in, sample_out;
	logic [7:0] reg_rdata, q;
	fpsm_pkg::fpsm_reg_req_type reg_req;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int wb;
	typedef struct {logic [1:0] off; int nw; logic [7:0] mode, mask, st; logic irq;} fpsm_row_type;
	fpsm_row_type rows [9] = '{
		'{2'h0, 0, 8'h00, 8'hff, 8'h88, 1'b0}, '{2'h1, 3, 8'h00, 8'hff, 8'h29, 1'b0},
		'{2'h1, 0, 8'h81, 8'hfb, 8'h29, 1'b0}, '{2'h3, 0, 8'h80, 8'hfb, 8'h8b, 1'b1},
		'{2'h3, 1, 8'h80, 8'hfb, 8'h1b, 1'b0}, '{2'h3, 0, 8'h81, 8'hfb, 8'h1b, 1'b1},
		'{2'h0, 2, 8'h81, 8'hfb, 8'h68, 1'b1}, '{2'h0, 1, 8'h80, 8'hfb, 8'h78, 1'b1},
		'{2'h0, 7, 8'h80, 8'hfb, 8'h68, 1'b0}};
	always #2 clock = ~clock;
	fpsm_host_model host (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.data_clock_in(data_clock_in), .converter_clock(converter_clock), .sample_in(sample_in));
	fpsm_monitor #(.WIDTH(14), .CTRL_DIV(4), .CYCLE_TICKS(2)) uut (.clock(clock), .rst(rst),
		.data_clock_in(data_clock_in), .sample_in(sample_in), .converter_clock(converter_clock),
		.sample_out(sample_out), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.sync_irq_enable(sync_irq_enable), .sync_irq(sync_irq));
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_word(input string n, input logic [13:0] e, input logic [13:0] g);
		chk_byte({n, " hi"}, {2'h0, e[13:8]}, {2'h0, g[13:8]});
		chk_byte({n, " lo"}, e[7:0], g[7:0]);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic mode(input logic [7:0] m, input int n);
		host.acc(1'b1, fpsm_pkg::ADDR_MODE_CONTROL, m, q);
		repeat (n) @(negedge clock);
	endtask
	task automatic stat;
		host.acc(1'b0, fpsm_pkg::ADDR_STATUS_OFFSET, 8'h00, q);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (6) @(negedge clock);
		rst = 1'b0;
		chk_byte("rdata at reset", 8'h00, reg_rdata);
		chk_byte("irq at reset", 8'h00, {7'h00, sync_irq});
		stat;
		chk_byte("valid early", 8'h00, q & 8'h08);
		repeat (40) @(negedge clock);
		$display("test reset done");
		foreach (rows[i]) begin
			host.acc(1'b1, fpsm_pkg::ADDR_STATUS_OFFSET, {6'h00, rows[i].off}, q);
			host.push(rows[i].nw, 0);
			sync_irq_enable = 1'b1;
			mode(rows[i].mode, 40);
			chk_byte("sync_irq", {7'h00, rows[i].irq}, {7'h00, sync_irq});
			stat;
			chk_byte("status", rows[i].st, q & rows[i].mask);
			sync_irq_enable = 1'b0;
			mode(8'h00, 40);
			chk_byte("irq cleared", 8'h00, {7'h00, sync_irq});
		end
		$display("test rows done");
		host.acc(1'b0, fpsm_pkg::ADDR_MODE_CONTROL, 8'h00, q);
		chk_byte("mode read", 8'h00, q);
		host.acc(1'b1, 5'h1f, 8'hff, q);
		host.acc(1'b0, 5'h1f, 8'h00, q);
		chk_byte("unmapped read", 8'h00, q);
		mode(8'h80, 40);
		stat;
		chk_byte("changed idle", 8'h00, q & 8'h04);
		host.push(1, 0);
		seen = 1'b0;
		repeat (12) begin
			stat;
			seen = seen | q[fpsm_pkg::FIELD_CHANGED];
		end
		chk_byte("changed", 8'h01, {7'h00, seen});
		mode(8'h00, 40);
		host.push(2, 0);
		repeat (40) @(negedge clock);
		stat;
		chk_byte("stopped pos", 8'h70, q & 8'h70);
		mode(8'h00, 40);
		host.push(2, 0);
		mode(8'h30, 40);
		stat;
		chk_byte("slow average", 8'h10, q & 8'h70);
		mode(8'h00, 40);
		stat;
		chk_byte("fast average", 8'h30, q & 8'h70);
		$display("test modes done");
		host.push(4, 0);
		mode(8'hc0, 80);
		stat;
		chk_byte("auto status", 8'h4b, q & 8'hfb);
		mode(8'h80, 40);
		host.acc(1'b1, fpsm_pkg::ADDR_STATUS_OFFSET, 8'h00, q);
		repeat (40) @(negedge clock);
		stat;
		chk_byte("auto off", 8'h78, q & 8'hfb);
		wb = host.wcnt;
		host.push(8, 1);
		for (int k = 0; k < 4; k++) begin
			host.acc(1'b1, fpsm_pkg::ADDR_STATUS_OFFSET, 8'(k), q);
			repeat (3) @(negedge clock);
			chk_word("sample", 14'h0a00 + 14'(wb + ((1 + k - wb) & 7)), sample_out);
		end
		mode(8'h00, 40);
		stat;
		chk_byte("wrapped pos", 8'h30, q & 8'h70);
		$display("test stream done");
		tally_and_finish;
	end
endmodule // fpsm_monitor_tb
